// file: inc/twsm_regs.svh
`ifndef TWSM_REGS_SVH
`define TWSM_REGS_SVH

// Register addresses
`define TWSM_ADDR_PCTL       16'h2d00
`define TWSM_ADDR_CFG        16'h2f01
`define TWSM_ADDR_THL        16'h2f02
`define TWSM_ADDR_THH        16'h2f03
`define TWSM_ADDR_DATA       16'h2f04
`define TWSM_ADDR_FLG        16'h2f05
`define TWSM_ADDR_ISTAT      16'h2f06
`define TWSM_ADDR_IMASK      16'h2f07

// Field positions
`define TWSM_PCTL_EN_BIT     6
`define TWSM_CFG_LSB_BIT     4
`define TWSM_CFG_START_BIT   3
`define TWSM_CFG_DATA_BIT    2
`define TWSM_CFG_STOP_BIT    1
`define TWSM_CFG_RSTRT_BIT   0
`define TWSM_FLG_BUSY_BIT    1
`define TWSM_FLG_ACK_BIT     0
`define TWSM_FLG_RSV_HI      7
`define TWSM_FLG_RSV_LO      2
`define TWSM_INT_DONE_BIT    0
`define TWSM_INT_ILL_BIT     1

// Reset values
`define TWSM_RESET_BYTE      8'h00
`define TWSM_RESET_INT       2'h0

// Bit timing: four quarters per SCL period, each (threshold + 1) cycles
`define TWSM_FIRST_QTR       2'h0
`define TWSM_SAMPLE_QTR      2'h1
`define TWSM_LAST_QTR        2'h3
`define TWSM_FIRST_BIT       3'h0
`define TWSM_LAST_BIT        3'h7

`endif

// file: inc/twsm_pkg.sv
package twsm_pkg;

    // Frame parts, Gray coded along idle-start-data-ack-stop
    typedef enum logic [2:0] {
        part_idle  = 3'h0,
        part_start = 3'h1,
        part_data  = 3'h3,
        part_ack   = 3'h2,
        part_stop  = 3'h6,
        part_rstrt = 3'h7
    } twsm_part_t;

    // Whole state of the master
    typedef struct packed {
        twsm_part_t  part;
        logic [15:0] cnt;
        logic [1:0]  qtr;
        logic [2:0]  bitn;
        logic        busy;
        logic        scl;
        logic        sda_low;
        logic        drive;
        logic [7:0]  pctl;
        logic [7:0]  cfg;
        logic [7:0]  thl;
        logic [7:0]  thh;
        logic [7:0]  data;
        logic [7:0]  flg;
        logic [1:0]  int_stat;
        logic [1:0]  int_mask;
        logic [7:0]  rdata;
        logic        irq;
        logic [2:0]  sync;
        logic        sda_in;
    } twsm_state_t;

endpackage : twsm_pkg

// file: src/twsm_top.sv
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`include "twsm_regs.svh"

module twsm_top (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [15:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    output logic             scl_o,
    output logic             scl_oe,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe,
    output logic             irq
);

    twsm_pkg::twsm_state_t s;
    twsm_pkg::twsm_state_t next_s;

    // Wire position of bit k in the data register
    function automatic logic [2:0] twsm_bit_pos(
        input logic [2:0] k,
        input logic       lsb_first
    );
        twsm_bit_pos = lsb_first ? k : (`TWSM_LAST_BIT - k);
    endfunction : twsm_bit_pos

    // Part that follows the given one, idle when the frame is over
    function automatic twsm_pkg::twsm_part_t twsm_next_part(
        input twsm_pkg::twsm_part_t cur,
        input logic [7:0]           cfg
    );
        twsm_pkg::twsm_part_t p;
        p = twsm_pkg::part_idle;
        if (cur == twsm_pkg::part_idle && cfg[`TWSM_CFG_START_BIT])
            p = twsm_pkg::part_start;
        else if ((cur == twsm_pkg::part_idle ||
                  cur == twsm_pkg::part_start) &&
                 cfg[`TWSM_CFG_DATA_BIT])
            p = twsm_pkg::part_data;
        else if (cur != twsm_pkg::part_stop &&
                 cur != twsm_pkg::part_rstrt)
        begin
            // STOP wins when both end parts are selected
            if (cfg[`TWSM_CFG_STOP_BIT])
                p = twsm_pkg::part_stop;
            else if (cfg[`TWSM_CFG_RSTRT_BIT])
                p = twsm_pkg::part_rstrt;
        end
        twsm_next_part = p;
    endfunction : twsm_next_part

    // SCL level and SDA pull-down for a quarter of a part
    function automatic logic [1:0] twsm_wave(
        input twsm_pkg::twsm_part_t part,
        input logic [1:0]           qtr,
        input logic                 bitv
    );
        logic [1:0] w;
        w = 2'h2;
        unique case (part)
            twsm_pkg::part_start,
            twsm_pkg::part_rstrt:
            begin
                // SDA falls while SCL is high
                unique case (qtr)
                    2'h0:    w = 2'h0;
                    2'h1:    w = 2'h2;
                    2'h2:    w = 2'h3;
                    default: w = 2'h1;
                endcase
            end
            twsm_pkg::part_data,
            twsm_pkg::part_ack:
            begin
                // Data set while SCL low, held through the high phase
                w = {(qtr == 2'h1 || qtr == 2'h2), ~bitv};
            end
            twsm_pkg::part_stop:
            begin
                // SDA rises while SCL is high, bus left released
                unique case (qtr)
                    2'h0:    w = 2'h1;
                    2'h1:    w = 2'h3;
                    default: w = 2'h2;
                endcase
            end
            twsm_pkg::part_idle:
            begin
                w = 2'h2;
            end
            default:
            begin
                w = 2'h2;
            end
        endcase
        twsm_wave = w;
    endfunction : twsm_wave

    // Next state: pin sync, register writes, frame engine, reads
    always_comb
    begin
        logic                 en;
        logic [15:0]          th;
        logic                 in_range;
        logic                 ill_wr;
        twsm_pkg::twsm_part_t np;
        logic [1:0]           nq;
        logic [2:0]           nb;
        logic                 bitv;
        logic [1:0]           w;
        en       = s.pctl[`TWSM_PCTL_EN_BIT];
        th       = {s.thh, s.thl};
        in_range = (reg_addr >= `TWSM_ADDR_CFG) &&
                   (reg_addr <= `TWSM_ADDR_DATA);
        ill_wr   = reg_wr && s.busy && in_range;
        np       = s.part;
        nq       = s.qtr;
        nb       = s.bitn;
        bitv     = 1'b1;
        w        = 2'h2;
        next_s   = s;

        // Three-stage synchroniser; change taken when stages 2 and 3 agree
        next_s.sync = {s.sync[1:0], sda_i};
        if (s.sync[1] == s.sync[2])
            next_s.sda_in = s.sync[2];

        // Register writes; writes to the frame range while busy are dropped
        if (ill_wr)
        begin
            next_s.int_stat[`TWSM_INT_ILL_BIT] = 1'b1;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                `TWSM_ADDR_PCTL:  next_s.pctl = reg_wdata;
                `TWSM_ADDR_CFG:   next_s.cfg  = reg_wdata;
                `TWSM_ADDR_THL:   next_s.thl  = reg_wdata;
                `TWSM_ADDR_THH:   next_s.thh  = reg_wdata;
                `TWSM_ADDR_DATA:  next_s.data = reg_wdata;
                `TWSM_ADDR_FLG:
                begin
                    // Busy is read-only; reserved bits are plain storage
                    next_s.flg[`TWSM_FLG_RSV_HI:`TWSM_FLG_RSV_LO] =
                        reg_wdata[`TWSM_FLG_RSV_HI:`TWSM_FLG_RSV_LO];
                    if (!s.busy)
                        next_s.flg[`TWSM_FLG_ACK_BIT] =
                            reg_wdata[`TWSM_FLG_ACK_BIT];
                end
                `TWSM_ADDR_ISTAT: next_s.int_stat = s.int_stat &
                                                    ~reg_wdata[1:0];
                `TWSM_ADDR_IMASK: next_s.int_mask = reg_wdata[1:0];
                default:          next_s.int_mask = s.int_mask;
            endcase
        end

        // Frame trigger by a data register write while idle and enabled
        if (reg_wr && !s.busy && en && reg_addr == `TWSM_ADDR_DATA)
        begin
            np = twsm_next_part(twsm_pkg::part_idle, s.cfg);
            if (np != twsm_pkg::part_idle)
            begin
                next_s.busy = 1'b1;
                next_s.part = np;
                next_s.qtr  = `TWSM_FIRST_QTR;
                next_s.bitn = `TWSM_FIRST_BIT;
                next_s.cnt  = 16'h0000;
                w = twsm_wave(np, `TWSM_FIRST_QTR,
                              reg_wdata[twsm_bit_pos(`TWSM_FIRST_BIT,
                                  s.cfg[`TWSM_CFG_LSB_BIT])]);
                next_s.scl     = w[1];
                next_s.sda_low = w[0];
            end
        end
        else if (s.busy && !en)
        begin
            // Disabling mid-frame abandons it and releases the bus
            next_s.busy    = 1'b0;
            next_s.part    = twsm_pkg::part_idle;
            next_s.scl     = 1'b1;
            next_s.sda_low = 1'b0;
        end
        else if (s.busy)
        begin
            if (s.cnt != th)
            begin
                next_s.cnt = s.cnt + 16'h0001;
            end
            else
            begin
                // One quarter of an SCL period has elapsed
                next_s.cnt = 16'h0000;
                if (s.qtr == `TWSM_SAMPLE_QTR)
                begin
                    // Sample SDA in the middle of the SCL high phase
                    if (s.part == twsm_pkg::part_data)
                        next_s.data[twsm_bit_pos(s.bitn,
                            s.cfg[`TWSM_CFG_LSB_BIT])] = s.sda_in;
                    else if (s.part == twsm_pkg::part_ack)
                        next_s.flg[`TWSM_FLG_ACK_BIT] = s.sda_in;
                end
                nq = s.qtr + 2'h1;
                if (s.qtr == `TWSM_LAST_QTR)
                begin
                    if (s.part == twsm_pkg::part_data &&
                        s.bitn != `TWSM_LAST_BIT)
                        nb = s.bitn + 3'h1;
                    else if (s.part == twsm_pkg::part_data)
                        np = twsm_pkg::part_ack;
                    else
                        np = twsm_next_part(s.part, s.cfg);
                end
                if (np == twsm_pkg::part_idle)
                begin
                    // Frame over; SCL stays as the last part left it
                    next_s.busy = 1'b0;
                    next_s.part = twsm_pkg::part_idle;
                    next_s.int_stat[`TWSM_INT_DONE_BIT] = 1'b1;
                end
                else
                begin
                    if (np == twsm_pkg::part_ack)
                        bitv = s.flg[`TWSM_FLG_ACK_BIT];
                    else
                        bitv = s.data[twsm_bit_pos(nb,
                            s.cfg[`TWSM_CFG_LSB_BIT])];
                    w = twsm_wave(np, nq, bitv);
                    // SDA stands from q0 to q3 of a bit, so a sampled
                    // value never feeds back onto the line mid-bit
                    if ((np == twsm_pkg::part_data ||
                         np == twsm_pkg::part_ack) &&
                        s.qtr != `TWSM_LAST_QTR)
                        w[0] = s.sda_low;
                    next_s.part    = np;
                    next_s.qtr     = nq;
                    next_s.bitn    = nb;
                    next_s.scl     = w[1];
                    next_s.sda_low = w[0];
                end
            end
        end
        else if (en)
        begin
            // Between frames SCL keeps its last level, low after data
            next_s.scl = s.scl;
        end
        else
        begin
            next_s.scl     = 1'b1;
            next_s.sda_low = 1'b0;
        end

        // Pins are driven only while the interface is enabled
        next_s.drive = next_s.pctl[`TWSM_PCTL_EN_BIT];
        // Pull-down cut with the enable, so the pin comes from one flop
        next_s.sda_low = next_s.sda_low & next_s.drive;

        // Level interrupt from unmasked sticky bits
        next_s.irq = |(next_s.int_stat & s.int_mask);

        // Read data stands for the one cycle after the read strobe
        next_s.rdata = `TWSM_RESET_BYTE;
        if (reg_rd)
        begin
            case (reg_addr)
                `TWSM_ADDR_PCTL:  next_s.rdata = s.pctl;
                `TWSM_ADDR_CFG:   next_s.rdata = s.cfg;
                `TWSM_ADDR_THL:   next_s.rdata = s.thl;
                `TWSM_ADDR_THH:   next_s.rdata = s.thh;
                `TWSM_ADDR_DATA:  next_s.rdata = s.data;
                `TWSM_ADDR_FLG:
                    next_s.rdata = {s.flg[`TWSM_FLG_RSV_HI:`TWSM_FLG_RSV_LO],
                                    s.busy,
                                    s.flg[`TWSM_FLG_ACK_BIT]};
                `TWSM_ADDR_ISTAT: next_s.rdata = {6'h00, s.int_stat};
                `TWSM_ADDR_IMASK: next_s.rdata = {6'h00, s.int_mask};
                default:          next_s.rdata = `TWSM_RESET_BYTE;
            endcase
        end
    end

    // State register
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            s.part     <= twsm_pkg::part_idle;
            s.cnt      <= 16'h0000;
            s.qtr      <= `TWSM_FIRST_QTR;
            s.bitn     <= `TWSM_FIRST_BIT;
            s.busy     <= 1'b0;
            s.scl      <= 1'b1;
            s.sda_low  <= 1'b0;
            s.drive    <= 1'b0;
            s.pctl     <= `TWSM_RESET_BYTE;
            s.cfg      <= `TWSM_RESET_BYTE;
            s.thl      <= `TWSM_RESET_BYTE;
            s.thh      <= `TWSM_RESET_BYTE;
            s.data     <= `TWSM_RESET_BYTE;
            s.flg      <= `TWSM_RESET_BYTE;
            s.int_stat <= `TWSM_RESET_INT;
            s.int_mask <= `TWSM_RESET_INT;
            s.rdata    <= `TWSM_RESET_BYTE;
            s.irq      <= 1'b0;
            s.sync     <= 3'h7;
            s.sda_in   <= 1'b1;
        end
        else
        begin
            s <= next_s;
        end
    end

    // Outputs straight from the state register, except sda_o held at 0
    assign reg_rdata = s.rdata;
    assign scl_o     = s.scl;
    assign scl_oe    = s.drive;
    assign sda_o     = 1'b0;            // Open drain: only ever pulls low
    assign sda_oe    = s.sda_low;
    assign irq       = s.irq;

endmodule : twsm_top

// file: tb/twsm_chk.sv
`timescale 1ns/1ps
`include "twsm_regs.svh"
module twsm_chk (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic        scl_o,
    input wire logic        scl_oe,
    input wire logic        sda_i,
    input wire logic        sda_o,
    input wire logic        sda_oe,
    input wire logic        irq
);
    logic [15:0] th;
    logic [19:0] hi;
    logic [19:0] lo;
    logic        stp;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Threshold shadow, SCL phase lengths, free phase after stop or reset
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            th <= 16'h0000;
            hi <= 20'h00000;
            lo <= 20'h00000;
            stp <= 1'b1;
        end
        else
        begin
            if (reg_wr && reg_addr == `TWSM_ADDR_THL)
                th[7:0] <= reg_wdata;
            if (reg_wr && reg_addr == `TWSM_ADDR_THH)
                th[15:8] <= reg_wdata;
            hi <= scl_o ? hi + 20'h1 : 20'h0;
            lo <= scl_o ? 20'h0 : lo + 20'h1;
            if ($fell(sda_oe) && scl_o)
                stp <= 1'b1;
            else if ($rose(scl_o))
                stp <= 1'b0;
        end
    end
    sequence s_start_edge;
        scl_o && $rose(sda_oe);
    endsequence
    sequence s_stop_edge;
        scl_o && $fell(sda_oe);
    endsequence
    a_scl_high : assert property (
        $fell(scl_o) && !stp |-> hi == {th, 1'b0} + 20'h2)
        else $error("scl high phase length wrong");
    a_scl_low : assert property (
        $rose(scl_o) && !stp |-> lo >= {th, 1'b0} + 20'h2)
        else $error("scl low phase too short");
    a_start_hold : assert property (
        s_start_edge |-> sda_oe until !scl_o)
        else $error("sda released during start");
    a_start_end : assert property (
        s_start_edge |-> ##[1:1000] $fell(scl_o))
        else $error("scl not lowered after start");
    a_stop_rel : assert property (
        s_stop_edge |-> (scl_o && !sda_oe) [*8])
        else $error("bus not released after stop");
    a_oe_gate : assert property (
        !scl_oe |-> !sda_oe)
        else $error("sda pulled while disabled");
    a_sda_open : assert property (
        sda_o == 1'b0)
        else $error("sda driven high");
    a_read_quiet : assert property (
        !$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read cycle");
    c_stop : cover property (s_stop_edge);
endmodule : twsm_chk

bind twsm_top twsm_chk u_chk (.sys_clk(sys_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .irq(irq));

// file: tb/twsm_slave.sv
`timescale 1ns/1ps
module twsm_slave (
    input  wire logic       scl,
    input  wire logic       sda,
    input  wire logic       ack_en,
    input  wire logic [7:0] tx,
    output logic            pull,
    output logic [7:0]      rx,
    output logic            ack_seen
);
    int k = 9;
    // Released until a start is seen
    initial
    begin
        pull = 1'b0;
        rx = 8'h00;
        ack_seen = 1'b0;
    end
    // Start seen while SCL high restarts the bit count
    always @(negedge sda)
        if (scl)
            k = -1;
    // Next bit laid out while SCL is low, acknowledge in slot 8
    always @(negedge scl)
    begin
        if (k < 9)
            k = k + 1;
        pull = (k < 8) ? !tx[7 - k] : (k == 8 && ack_en);
    end
    // Wire bits and master acknowledge taken on SCL rise
    always @(posedge scl)
        if (k >= 0 && k < 8)
            rx[7 - k] = sda;
        else if (k == 8)
            ack_seen = sda;
endmodule : twsm_slave

// file: tb/tb.sv
`timescale 1ns/1ps
`include "twsm_regs.svh"
module tb;
    logic        sys_clk;
    logic        rst;
    logic [15:0] reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic        scl_o;
    logic        scl_oe;
    logic        sda_o;
    logic        sda_oe;
    logic        irq;
    logic        pull;
    logic        ack_en;
    logic [7:0]  tx;
    logic [7:0]  rx;
    logic        ack_seen;
    logic [7:0]  d;
    wire logic   sda;
    int          failures;
    int          n_compared;
    int          cyc;
    int          t0;
    // Pulled-up wire: low while either side pulls
    assign sda = !(sda_oe || pull);
    twsm_top uut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .scl_o(scl_o), .scl_oe(scl_oe),
        .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));
    twsm_slave u_slv (.scl(scl_o), .sda(sda), .ack_en(ack_en), .tx(tx),
        .pull(pull), .rx(rx), .ack_seen(ack_seen));
    // Clock and cycle count
    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
        cyc++;
    task check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task rd(input logic [15:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd
    task rdc(input logic [15:0] a, input logic [7:0] exp);
        rd(a, d);
        check(d, exp);
    endtask : rdc
    task idle();
        for (int i = 0; i < 4000; i++)
        begin
            rd(`TWSM_ADDR_FLG, d);
            if (d[1] === 1'b0)
                break;
        end
    endtask : idle
    task frame(input logic [7:0] c, input logic [7:0] v);
        wr(`TWSM_ADDR_CFG, c);
        wr(`TWSM_ADDR_DATA, v);
        idle();
    endtask : frame
    task end_of_test();
        $display("failures=%0d compared=%0d", failures, n_compared);
        if (failures == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test
    // Watchdog against a hung frame
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        end_of_test();
    end
    // Main sequence
    initial
    begin
        logic [15:0] ra [9];
        ra = '{16'h2d00, 16'h2f01, 16'h2f02, 16'h2f03, 16'h2f04,
            16'h2f05, 16'h2f06, 16'h2f07, 16'h2f10};
        rst = 1'b1;
        {reg_addr, reg_wdata, reg_wr, reg_rd, ack_en} = '0;
        tx = 8'hff;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        wr(16'h2f10, 8'h5a);
        foreach (ra[i])
            rdc(ra[i], 8'h00);
        wr(`TWSM_ADDR_PCTL, 8'h40);
        wr(`TWSM_ADDR_THL, 8'h03);
        wr(`TWSM_ADDR_IMASK, 8'h03);
        rdc(`TWSM_ADDR_PCTL, 8'h40);
        wr(`TWSM_ADDR_CFG, 8'he8);
        rdc(`TWSM_ADDR_CFG, 8'he8);
        wr(`TWSM_ADDR_DATA, 8'h00);
        rdc(`TWSM_ADDR_FLG, 8'h02);
        wr(`TWSM_ADDR_CFG, 8'h04);
        rdc(`TWSM_ADDR_CFG, 8'he8);
        rdc(`TWSM_ADDR_ISTAT, 8'h02);
        check(irq, 8'h01);
        idle();
        rdc(`TWSM_ADDR_ISTAT, 8'h03);
        wr(`TWSM_ADDR_ISTAT, 8'h03);
        wr(`TWSM_ADDR_IMASK, 8'h00);
        ack_en <= 1'b1;
        wr(`TWSM_ADDR_FLG, 8'h01);
        frame(8'h0c, 8'ha5);
        check(rx, 8'ha5);
        check(scl_o, 8'h00);
        rdc(`TWSM_ADDR_FLG, 8'h00);
        rdc(`TWSM_ADDR_DATA, 8'ha5);
        check(irq, 8'h00);
        rdc(`TWSM_ADDR_ISTAT, 8'h01);
        wr(`TWSM_ADDR_IMASK, 8'h01);
        rdc(`TWSM_ADDR_IMASK, 8'h01);
        check(irq, 8'h01);
        wr(`TWSM_ADDR_ISTAT, 8'h01);
        rdc(`TWSM_ADDR_ISTAT, 8'h00);
        check(irq, 8'h00);
        wr(`TWSM_ADDR_FLG, 8'h01);
        frame(8'h1c, 8'h01);
        check(rx, 8'h80);
        ack_en <= 1'b0;
        tx <= 8'h3c;
        wr(`TWSM_ADDR_FLG, 8'h01);
        frame(8'h0c, 8'hff);
        rdc(`TWSM_ADDR_DATA, 8'h3c);
        check(ack_seen, 8'h01);
        tx <= 8'h1e;
        wr(`TWSM_ADDR_FLG, 8'h00);
        frame(8'h1c, 8'hff);
        rdc(`TWSM_ADDR_DATA, 8'h78);
        check(ack_seen, 8'h00);
        // Slave lays out its next bit after any start, so release it first
        tx <= 8'hff;
        ack_en <= 1'b1;
        wr(`TWSM_ADDR_CFG, 8'h01);
        wr(`TWSM_ADDR_DATA, 8'h00);
        #1 t0 = cyc;
        idle();
        check(cyc - t0 >= 16 && cyc - t0 <= 18, 8'h01);
        check(scl_o, 8'h00);
        wr(`TWSM_ADDR_FLG, 8'h01);
        wr(`TWSM_ADDR_CFG, 8'h0e);
        wr(`TWSM_ADDR_DATA, 8'hc3);
        #1 t0 = cyc;
        idle();
        check(cyc - t0 >= 176 && cyc - t0 <= 180, 8'h01);
        check(scl_o, 8'h01);
        check(rx, 8'hc3);
        // No part selected: a data write must not start a frame
        wr(`TWSM_ADDR_CFG, 8'he0);
        wr(`TWSM_ADDR_DATA, 8'h55);
        rdc(`TWSM_ADDR_FLG, 8'h00);
        wr(`TWSM_ADDR_PCTL, 8'h00);
        rdc(`TWSM_ADDR_PCTL, 8'h00);
        check(scl_oe, 8'h00);
        end_of_test();
    end
endmodule : tb
